// File: core/uhqde_defs.svh
// offsets, field positions and packet codes of the queue descriptor engine
`ifndef UHQDE_DEFS_SVH
`define UHQDE_DEFS_SVH
`define UHQDE_QH_LINK      8'h00
`define UHQDE_QH_CHAR      8'h04
`define UHQDE_QH_CAPS      8'h08
`define UHQDE_QH_CUR       8'h0c
`define UHQDE_QH_OVL       8'h10
`define UHQDE_TD_TOKEN     8'h08
`define UHQDE_TD_BUF       8'h0c
`define UHQDE_PTR_MSB      31
`define UHQDE_PTR_LSB      5
`define UHQDE_MPS_MSB      26
`define UHQDE_MPS_LSB      16
`define UHQDE_HEAD_BIT     15
`define UHQDE_EPS_MSB      13
`define UHQDE_EPS_LSB      12
`define UHQDE_EP_MSB       11
`define UHQDE_EP_LSB       8
`define UHQDE_ADDR_MSB     6
`define UHQDE_TOG_BIT      31
`define UHQDE_CNT_MSB      30
`define UHQDE_CNT_LSB      16
`define UHQDE_IOC_BIT      15
`define UHQDE_CERR_MSB     11
`define UHQDE_CERR_LSB     10
`define UHQDE_PID_MSB      9
`define UHQDE_PID_LSB      8
`define UHQDE_ST_ACTIVE    7
`define UHQDE_ST_HALT      6
`define UHQDE_ST_BUFERR    5
`define UHQDE_ST_BABBLE    4
`define UHQDE_ST_XACT      3
`define UHQDE_ST_PING      0
`define UHQDE_TOK_OUT      8'he1
`define UHQDE_TOK_IN       8'h69
`define UHQDE_TOK_SETUP    8'h2d
`define UHQDE_TOK_PING     8'hb4
`define UHQDE_SPEED_HIGH   2'h2
`define UHQDE_PIDC_OUT     2'h0
`define UHQDE_PIDC_IN      2'h1
`define UHQDE_PIDC_SETUP   2'h2
`endif

// File: core/uhqde_pkg.sv
// types of the queue descriptor engine
package uhqde_pkg;
  typedef enum logic [1:0] {UHQDE_RES_OK, UHQDE_RES_STALL, UHQDE_RES_BABBLE, UHQDE_RES_ERR}
    uhqde_res_t;
endpackage

// File: core/uhqde_buf2.sv
// two-entry valid/ready buffer on the transaction request path
`timescale 1ns/100ps
module uhqde_buf2 #(
  parameter int W = 48
) (
  input  wire logic         core_clk,
  input  wire logic         resetn,
  input  wire logic         inValid,
  output logic              inReady,
  input  wire logic [W-1:0] inData,
  output logic              outValid,
  input  wire logic         outReady,
  output logic [W-1:0]      outData
);
  logic [W-1:0] mem_q [2];
  logic         wrPtr_q;
  logic         rdPtr_q;
  logic [1:0]   cnt_q;
  wire          doWr = inValid & inReady;
  wire          doRd = outValid & outReady;
  assign inReady  = (cnt_q != 2'h2);
  assign outValid = (cnt_q != 2'h0);
  assign outData  = mem_q[rdPtr_q];
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wrPtr_q <= 1'b0;
      rdPtr_q <= 1'b0;
      cnt_q   <= 2'h0;
    end
    else
    begin
      if (doWr)
        wrPtr_q <= ~wrPtr_q;
      if (doRd)
        rdPtr_q <= ~rdPtr_q;
      cnt_q <= cnt_q + {1'b0, doWr} - {1'b0, doRd};
    end
  end
  always_ff @(posedge core_clk)
  begin
    if (doWr)
      mem_q[wrPtr_q] <= inData;
  end
endmodule // uhqde_buf2

// File: core/uhqde_engine.sv
// queue head and transfer descriptor execution engine
// Notes on behaviour
// - endpoint characteristics longword is never written by the engine
// - head-of-list bit is decoded and shown as a marker
// - speed field decoded: 00 full, 01 low, 10 high, 11 reserved
// - token carries endpoint number and device address from queue head
// - queue head with a nonzero mask served only when its microframe mask bit is set; zero mask always served
// - current descriptor address written to queue head on fetch
// - progress kept in overlay, results copied back to descriptor
// - follow overlay next pointer then descriptor next, stop on terminate
// - toggle bit drives data sequence and flips on success of a non-PING transaction
// - byte count reduced by bytes moved, only on success
// - zero count descriptor does one zero-length transaction then retires
// - completion interrupt pulse when ioc set and descriptor completes
// - error counter decremented on each failure and written back
// - counter one to zero: clear active, set halt and cause, error irq
// - pid code 00 OUT e1, 01 IN 69, 10 SETUP 2d
// - transactions only while active bit is set
// - halt on babble, exhaustion or stall; halting clears active
// - buffer error on overrun or underrun; either one counts as a failed transaction
// - babble sets babble bit and halt
// - failed transaction without overrun or underrun sets transaction error bit
// - high-speed OUT with ping state 1 issues PING instead of OUT
// - horizontal link bits 31 to 5 give next queue head address
`timescale 1ns/100ps
`include "uhqde_defs.svh"
module uhqde_engine
  import uhqde_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        start,
  input  wire logic [31:0] qhAddr,
  input  wire logic [2:0]  uframe,
  output logic             busy,
  output logic [31:0]      nextQhAddr,
  output logic             headOfList,
  output logic [1:0]       endpointSpeed,
  output logic             memReq,
  output logic             memWe,
  output logic [31:0]      memAddr,
  output logic [31:0]      memWdata,
  input  wire logic        memAck,
  input  wire logic [31:0] memRdata,
  output logic             txnValid,
  input  wire logic        txnReady,
  output logic [47:0]      txnData,
  input  wire logic        resValid,
  input  wire logic [1:0]  resCode,
  input  wire logic [10:0] resBytes,
  input  wire logic        resOverrun,
  input  wire logic        resUnderrun,
  output logic             irqComplete,
  output logic             irqError,
  input  wire logic        errIrqEnable
);
  // ==========================================================
  // state
  // ==========================================================
  typedef enum logic [3:0] {S_IDLE, S_LINK, S_CHAR, S_CAPS, S_NEXT, S_TDNEXT, S_TDTOK,
    S_CUR, S_ISSUE, S_WAIT, S_OVL, S_WBTOK, S_DONE} uhqde_st_t;
  uhqde_st_t   st_q;
  logic [31:0] qh_q, char_q, tdAddr_q, tdNext_q, tok_q, link_q;
  logic [7:0]  smask_q;
  logic        memReq_q, memWe_q, busy_q, irqC_q, irqE_q;
  logic [31:0] memAddr_q, memWdata_q;
  logic        iss_q;
  // ==========================================================
  // decode
  // ==========================================================
  wire [1:0]  pidCode  = tok_q[`UHQDE_PID_MSB:`UHQDE_PID_LSB];
  wire [14:0] count    = tok_q[`UHQDE_CNT_MSB:`UHQDE_CNT_LSB];
  wire [1:0]  cerr     = tok_q[`UHQDE_CERR_MSB:`UHQDE_CERR_LSB];
  wire [1:0]  speed    = char_q[`UHQDE_EPS_MSB:`UHQDE_EPS_LSB];
  wire        isHigh   = (speed == `UHQDE_SPEED_HIGH);
  wire        doPing   = isHigh & (pidCode == `UHQDE_PIDC_OUT) & tok_q[`UHQDE_ST_PING];
  wire [7:0]  pidTok   = doPing ? `UHQDE_TOK_PING :
                         (pidCode == `UHQDE_PIDC_IN) ? `UHQDE_TOK_IN :
                         (pidCode == `UHQDE_PIDC_SETUP) ? `UHQDE_TOK_SETUP :
                         `UHQDE_TOK_OUT;
  wire [10:0] mps      = char_q[`UHQDE_MPS_MSB:`UHQDE_MPS_LSB];
  wire [14:0] mps15    = {4'h0, mps};
  wire [10:0] xfer     = (count < mps15) ? count[10:0] : mps;
  // token word: pid, endpoint, address, toggle, length, speed
  wire [47:0] txnWord  = {pidTok, char_q[`UHQDE_EP_MSB:`UHQDE_EP_LSB],
                          char_q[`UHQDE_ADDR_MSB:0], tok_q[`UHQDE_TOG_BIT],
                          xfer, speed, 15'h0000};
  wire        maskHit  = smask_q[uframe];
  wire        active   = tok_q[`UHQDE_ST_ACTIVE];
  wire        txnIn    = (st_q == S_ISSUE) & ~iss_q;
  wire        txnInRdy;
  // ==========================================================
  // result of a transaction
  // ==========================================================
  wire        resOk    = (resCode == UHQDE_RES_OK) & ~resOverrun & ~resUnderrun;
  wire        resStall = (resCode == UHQDE_RES_STALL);
  wire        resBab   = (resCode == UHQDE_RES_BABBLE);
  wire        resFail  = ~resOk & ~resStall & ~resBab;
  wire [14:0] cntLeft  = count - {4'h0, resBytes};
  wire        lastErr  = (cerr == 2'h1);
  wire        fatal    = resStall | resBab | (resFail & lastErr);
  wire        finished = resOk & (doPing ? 1'b0 : (cntLeft == 15'h0000 || resBytes < mps));
  logic [31:0] tokNew;
  always_comb
  begin
    tokNew = tok_q;
    if (resOk)
    begin
      if (doPing)
        tokNew[`UHQDE_ST_PING] = 1'b0;
      else
      begin
        tokNew[`UHQDE_CNT_MSB:`UHQDE_CNT_LSB] = cntLeft;
        tokNew[`UHQDE_TOG_BIT] = ~tok_q[`UHQDE_TOG_BIT];
      end
      tokNew[`UHQDE_CERR_MSB:`UHQDE_CERR_LSB] = 2'h3;
    end
    else if (resFail)
    begin
      tokNew[`UHQDE_CERR_MSB:`UHQDE_CERR_LSB] = cerr - 2'h1;
      tokNew[`UHQDE_ST_XACT] = ~(resOverrun | resUnderrun) | tok_q[`UHQDE_ST_XACT];
      tokNew[`UHQDE_ST_BUFERR] = resOverrun | resUnderrun | tok_q[`UHQDE_ST_BUFERR];
    end
    if (resBab)
      tokNew[`UHQDE_ST_BABBLE] = 1'b1;
    if (fatal)
    begin
      tokNew[`UHQDE_ST_HALT] = 1'b1;
      tokNew[`UHQDE_ST_ACTIVE] = 1'b0;
    end
    if (finished)
      tokNew[`UHQDE_ST_ACTIVE] = 1'b0;
  end
  // ==========================================================
  // memory request helper and descriptor state machine
  // ==========================================================
  wire        memDone  = memReq_q & memAck;
  wire        hasNext  = ~tdNext_q[0];
  wire [31:0] tdNextA  = {tdNext_q[`UHQDE_PTR_MSB:`UHQDE_PTR_LSB], 5'h00};
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_q <= S_IDLE;
      qh_q <= 32'h0; char_q <= 32'h0; tdAddr_q <= 32'h0; tdNext_q <= 32'h0;
      tok_q <= 32'h0; link_q <= 32'h0; smask_q <= 8'h00;
      memReq_q <= 1'b0; memWe_q <= 1'b0; memAddr_q <= 32'h0; memWdata_q <= 32'h0;
      busy_q <= 1'b0; irqC_q <= 1'b0; irqE_q <= 1'b0; iss_q <= 1'b0;
    end
    else
    begin
      irqC_q <= 1'b0;
      irqE_q <= 1'b0;
      if (memDone)
        memReq_q <= 1'b0;
      case (st_q)
        S_IDLE:
        begin
          if (start)
          begin
            qh_q <= {qhAddr[31:5], 5'h00};
            busy_q <= 1'b1;
            memReq_q <= 1'b1; memWe_q <= 1'b0;
            memAddr_q <= {qhAddr[31:5], 5'h00} + {24'h0, `UHQDE_QH_LINK};
            st_q <= S_LINK;
          end
        end
        S_LINK:
          if (memDone)
          begin
            link_q <= memRdata;
            memReq_q <= 1'b1;
            memAddr_q <= qh_q + {24'h0, `UHQDE_QH_CHAR};
            st_q <= S_CHAR;
          end
        S_CHAR:
          if (memDone)
          begin
            char_q <= memRdata;
            memReq_q <= 1'b1;
            memAddr_q <= qh_q + {24'h0, `UHQDE_QH_CAPS};
            st_q <= S_CAPS;
          end
        S_CAPS:
          if (memDone)
          begin
            smask_q <= memRdata[7:0];
            memReq_q <= 1'b1;
            memAddr_q <= qh_q + {24'h0, `UHQDE_QH_OVL};
            st_q <= S_NEXT;
          end
        S_NEXT:
          if (memDone)
          begin
            tdNext_q <= memRdata;
            // zero mask means async queue head, always served
            if ((smask_q != 8'h00) && !maskHit)
              st_q <= S_DONE;
            else
              st_q <= S_TDNEXT;
          end
        S_TDNEXT:
          if (!hasNext)
            st_q <= S_DONE;
          else if (!memReq_q)
          begin
            tdAddr_q <= tdNextA;
            memReq_q <= 1'b1; memWe_q <= 1'b0;
            memAddr_q <= tdNextA;
            st_q <= S_TDTOK;
          end
          else if (memDone)
          begin
            tdNext_q <= memRdata;
            memReq_q <= 1'b1;
            memAddr_q <= tdAddr_q + {24'h0, `UHQDE_TD_TOKEN};
            st_q <= S_TDTOK;
          end
        S_TDTOK:
          if (memDone && memAddr_q == tdAddr_q)
          begin
            tdNext_q <= memRdata;
            memReq_q <= 1'b1;
            memAddr_q <= tdAddr_q + {24'h0, `UHQDE_TD_TOKEN};
          end
          else if (memDone)
          begin
            tok_q <= memRdata;
            memReq_q <= 1'b1; memWe_q <= 1'b1;
            memAddr_q <= qh_q + {24'h0, `UHQDE_QH_CUR};
            memWdata_q <= tdAddr_q;
            st_q <= S_CUR;
          end
        S_CUR:
          if (memDone)
          begin
            memWe_q <= 1'b0;
            iss_q <= 1'b0;
            st_q <= active ? S_ISSUE : S_DONE;
          end
        S_ISSUE:
        begin
          if (txnIn && txnInRdy)
            iss_q <= 1'b1;
          if (resValid && (iss_q || (txnIn && txnInRdy)))
          begin
            tok_q <= tokNew;
            memReq_q <= 1'b1; memWe_q <= 1'b1;
            memAddr_q <= qh_q + {24'h0, `UHQDE_QH_OVL} + {24'h0, `UHQDE_TD_TOKEN};
            memWdata_q <= tokNew;
            st_q <= S_OVL;
          end
        end
        S_OVL:
          if (memDone)
          begin
            iss_q <= 1'b0;
            if (tok_q[`UHQDE_ST_ACTIVE])
            begin
              memWe_q <= 1'b0;
              st_q <= S_ISSUE;
            end
            else
            begin
              memReq_q <= 1'b1;
              memAddr_q <= tdAddr_q + {24'h0, `UHQDE_TD_TOKEN};
              memWdata_q <= tok_q;
              st_q <= S_WBTOK;
            end
          end
        S_WBTOK:
          if (memDone)
          begin
            memWe_q <= 1'b0;
            irqC_q <= tok_q[`UHQDE_IOC_BIT] & ~tok_q[`UHQDE_ST_HALT];
            irqE_q <= tok_q[`UHQDE_ST_HALT] & errIrqEnable;
            st_q <= tok_q[`UHQDE_ST_HALT] ? S_DONE : S_TDNEXT;
          end
        S_DONE:
        begin
          busy_q <= 1'b0;
          st_q <= S_IDLE;
        end
        default:
          st_q <= S_IDLE;
      endcase
    end
  end
  // ==========================================================
  // transaction request buffer
  // ==========================================================
  logic [47:0] bufOut;
  logic        bufValid;
  logic        txnV_q;
  logic [47:0] txnD_q;
  // pop only when the output stage takes the word, else a stalled word repeats
  wire         txnAdv = ~txnV_q | txnReady;
  uhqde_buf2 #(.W(48)) u_buf (
    .core_clk (core_clk),
    .resetn   (resetn),
    .inValid  (txnIn),
    .inReady  (txnInRdy),
    .inData   (txnWord),
    .outValid (bufValid),
    .outReady (txnAdv),
    .outData  (bufOut)
  );
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      txnV_q <= 1'b0;
      txnD_q <= 48'h0;
    end
    else if (txnAdv)
    begin
      txnV_q <= bufValid;
      txnD_q <= bufOut;
    end
  end
  logic [31:0] nextQh_q;
  logic        head_q;
  logic [1:0]  eps_q;
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      nextQh_q <= 32'h0;
      head_q   <= 1'b0;
      eps_q    <= 2'h0;
    end
    else
    begin
      nextQh_q <= {link_q[`UHQDE_PTR_MSB:`UHQDE_PTR_LSB], 5'h00};
      head_q   <= char_q[`UHQDE_HEAD_BIT];
      eps_q    <= speed;
    end
  end
  assign busy          = busy_q;
  assign nextQhAddr    = nextQh_q;
  assign headOfList    = head_q;
  assign endpointSpeed = eps_q;
  assign memReq        = memReq_q;
  assign memWe         = memWe_q;
  assign memAddr       = memAddr_q;
  assign memWdata      = memWdata_q;
  assign txnValid      = txnV_q;
  assign txnData       = txnD_q;
  assign irqComplete   = irqC_q;
  assign irqError      = irqE_q;
  // ==========================================================
  // checks
  // ==========================================================
  a_char_readonly: assert property (@(posedge core_clk) disable iff (!resetn)
    memReq && memWe |-> memAddr != qh_q + 32'h4) else $error("char word written");
  a_cur_written: assert property (@(posedge core_clk) disable iff (!resetn)
    st_q == S_CUR && memReq |-> memWe && memWdata == tdAddr_q) else $error("cur ptr");
  a_align_word: assert property (@(posedge core_clk) disable iff (!resetn)
    memReq |-> memAddr[1:0] == 2'h0) else $error("unaligned access");
  a_halt_clears: assert property (@(posedge core_clk) disable iff (!resetn)
    tok_q[`UHQDE_ST_HALT] && $changed(tok_q) |-> !tok_q[`UHQDE_ST_ACTIVE])
    else $error("halt with active");
  a_babble_halts: assert property (@(posedge core_clk) disable iff (!resetn)
    $rose(tok_q[`UHQDE_ST_BABBLE]) |-> tok_q[`UHQDE_ST_HALT]) else $error("babble");
  a_issue_active: assert property (@(posedge core_clk) disable iff (!resetn)
    txnIn |-> active) else $error("issue inactive");
  a_ping_token: assert property (@(posedge core_clk) disable iff (!resetn)
    txnIn && doPing |-> txnWord[47:40] == 8'hb4) else $error("ping token");
  a_err_irq: assert property (@(posedge core_clk) disable iff (!resetn)
    irqError |-> $past(tok_q[`UHQDE_ST_HALT]) && $past(errIrqEnable)) else $error("err irq");
endmodule // uhqde_engine

// File: tb/uhqde_partner.sv
// far side model: system memory and a responding usb endpoint
`timescale 1ns/100ps
module uhqde_partner (
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        cfgSlow,
  input  wire logic [1:0]  cfgCode,
  input  wire logic        cfgOverrun,
  input  wire logic        memReq,
  input  wire logic        memWe,
  input  wire logic [31:0] memAddr,
  input  wire logic [31:0] memWdata,
  output logic             memAck,
  output logic [31:0]      memRdata,
  input  wire logic        txnValid,
  output logic             txnReady,
  input  wire logic [47:0] txnData,
  output logic             resValid,
  output logic [1:0]       resCode,
  output logic [10:0]      resBytes,
  output logic             resOverrun,
  output logic             resUnderrun
);
  logic [31:0] mem [0:255];
  logic [2:0]  memWait;
  logic [1:0]  stallCnt;
  logic [3:0]  pendCnt;
  logic [10:0] reqLen;
  logic        reqIn;
  logic        accept;
  logic        fire;
  // ======
  // memory, slow mode adds wait states
  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      memAck <= 1'b0;
      memRdata <= 32'h0;
      memWait <= 3'h0;
    end
    else
    begin
      memAck <= 1'b0;
      // idle bus toggles so stale data never looks valid
      memRdata <= ~memRdata;
      if (!memAck && memReq && memWait >= (cfgSlow ? 3'h3 : 3'h0))
      begin
        memAck <= 1'b1;
        memWait <= 3'h0;
        memRdata <= mem[memAddr[9:2]];
        if (memWe)
          mem[memAddr[9:2]] <= memWdata;
      end
      else
        memWait <= (memReq && !memAck) ? memWait + 3'h1 : 3'h0;
    end
  end
  // ======
  // endpoint: stalls ready in slow mode, answers one result per transaction
  assign txnReady = !cfgSlow || (stallCnt == 2'h3);
  assign accept = txnValid && txnReady;
  assign fire = (pendCnt == 4'h1);
  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      stallCnt <= 2'h0;
      pendCnt <= 4'h0;
      resValid <= 1'b0;
      resCode <= 2'h0;
      resBytes <= 11'h0;
      resOverrun <= 1'b0;
      resUnderrun <= 1'b0;
      reqLen <= 11'h0;
      reqIn <= 1'b0;
    end
    else
    begin
      if (accept)
        stallCnt <= 2'h0;
      else if (txnValid && !txnReady)
        stallCnt <= stallCnt + 2'h1;
      resValid <= fire;
      resCode <= fire ? cfgCode : ~resCode;
      resBytes <= fire ? reqLen : ~resBytes;
      resOverrun <= fire && cfgOverrun && reqIn;
      resUnderrun <= fire && cfgOverrun && !reqIn;
      if (accept)
      begin
        pendCnt <= cfgSlow ? 4'h6 : 4'h1;
        reqLen <= txnData[27:17];
        reqIn <= (txnData[47:40] == 8'h69);
      end
      else if (pendCnt != 4'h0)
        pendCnt <= pendCnt - 4'h1;
    end
  end
endmodule // uhqde_partner

// File: tb/tb_top.sv
// self-checking bench of the queue descriptor engine
`timescale 1ns/100ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin numErrors++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb_top;
  logic        coreClk, resetn, start, busy, hol, memReq, memWe, memAck;
  logic        txnValid, txnReady, resValid, resOv, resUn, irqC, irqE;
  logic        errEn, cSlow, cOvr;
  logic [1:0]  spd, resCode, cCode;
  logic [2:0]  uframe;
  logic [7:0]  firstTok;
  logic [10:0] resBytes;
  logic [31:0] nextQh, memAddr, memWdata, memRdata;
  logic [47:0] txnData, lastTxn;
  int          numErrors, checked, nTxn, nComp, nErr, k;
  logic [7:0]  toks [3] = '{8'he1, 8'h69, 8'h2d};
  logic [1:0]  eCode [4] = '{2'h3, 2'h1, 2'h2, 2'h0};
  logic [7:0]  eSt [4] = '{8'h48, 8'h40, 8'h50, 8'h60};
  int          eN [4] = '{3, 1, 1, 1};
  localparam logic [31:0] CH = 32'h00404315;

  uhqde_engine DUT (.core_clk(coreClk), .resetn(resetn), .start(start),
    .qhAddr(32'h40), .uframe(uframe), .busy(busy), .nextQhAddr(nextQh),
    .headOfList(hol), .endpointSpeed(spd), .memReq(memReq), .memWe(memWe),
    .memAddr(memAddr), .memWdata(memWdata), .memAck(memAck), .memRdata(memRdata),
    .txnValid(txnValid), .txnReady(txnReady), .txnData(txnData),
    .resValid(resValid), .resCode(resCode), .resBytes(resBytes),
    .resOverrun(resOv), .resUnderrun(resUn), .irqComplete(irqC),
    .irqError(irqE), .errIrqEnable(errEn));
  uhqde_partner P (.core_clk(coreClk), .resetn(resetn), .cfgSlow(cSlow),
    .cfgCode(cCode), .cfgOverrun(cOvr), .memReq(memReq), .memWe(memWe),
    .memAddr(memAddr), .memWdata(memWdata), .memAck(memAck),
    .memRdata(memRdata), .txnValid(txnValid), .txnReady(txnReady),
    .txnData(txnData), .resValid(resValid), .resCode(resCode),
    .resBytes(resBytes), .resOverrun(resOv), .resUnderrun(resUn));
  // ======
  // helpers
  function automatic logic [31:0] tok(input logic dt, input logic [14:0] n,
    input logic ioc, input logic [1:0] ce, input logic [1:0] pid, input logic [7:0] st);
    return {dt, n, ioc, 3'h0, ce, pid, st};
  endfunction
  task automatic setq(input logic [31:0] ch, input logic [7:0] sm, input logic [31:0] nx);
    P.mem[16] = 32'h102;
    P.mem[17] = ch;
    P.mem[18] = 32'h40000000 | sm;
    P.mem[20] = nx;
  endtask
  task automatic settd(input int ix, input logic [31:0] nx, input logic [31:0] t);
    P.mem[ix] = nx;
    P.mem[ix + 2] = t;
  endtask
  task automatic run(input logic [1:0] code, input logic slow, input logic ovr);
    int w;
    cCode = code;
    cSlow = slow;
    cOvr = ovr;
    nTxn = 0;
    nComp = 0;
    nErr = 0;
    @(negedge coreClk);
    start = 1'b1;
    @(negedge coreClk);
    start = 1'b0;
    for (w = 0; w < 3000 && busy !== 1'b0; w++)
      @(negedge coreClk);
    `CHK(busy, 1'b0)
  endtask
  task printVerdict;
    $display("checks %0d mismatches %0d", checked, numErrors);
    if (numErrors == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ======
  // clock, monitor, watchdog
  initial
  begin
    coreClk = 1'b0;
    forever #10 coreClk = ~coreClk;
  end
  always @(posedge coreClk)
  begin
    if (memReq && memAck)
      `CHK(memAddr[1:0], 2'h0)
    if (memReq && memAck && memWe)
      `CHK(memAddr !== 32'h44, 1'b1)
    if (txnValid && txnReady)
    begin
      if (nTxn == 0)
        firstTok = txnData[47:40];
      lastTxn = txnData;
      nTxn++;
    end
    if (irqC === 1'b1)
      nComp++;
    if (irqE === 1'b1)
      nErr++;
  end
  initial
  begin
    #(40000 * 20);
    numErrors++;
    printVerdict;
  end
  // ======
  // tests
  initial
  begin
    resetn = 1'b0;
    start = 1'b0;
    uframe = 3'h0;
    errEn = 1'b1;
    cCode = 2'h0;
    cSlow = 1'b0;
    cOvr = 1'b0;
    repeat (2) @(negedge coreClk);
    resetn = 1'b1;
    setq(CH | 32'h8000, 8'h00, 32'h80);
    settd(32, 32'h1, tok(1, 8, 1, 3, 0, 8'h80));
    run(0, 0, 0);
    `CHK(lastTxn, {8'he1, 4'h3, 7'h15, 1'b1, 11'd8, 2'h0, 15'h0})
    `CHK(P.mem[34], tok(0, 0, 1, 3, 0, 8'h00))
    `CHK(P.mem[19], 32'h80)
    `CHK(nComp, 1)
    `CHK(nextQh, 32'h100)
    `CHK({hol, spd}, 3'b100)
    $display("test basic done");
    for (k = 0; k < 3; k++)
    begin
      setq(CH | (k << 12), 8'h00, 32'h80);
      settd(32, 32'h1, tok(k != 2, 8, 0, 3, k[1:0], 8'h80));
      run(0, 0, 0);
      `CHK(lastTxn[47:40], toks[k])
      `CHK(spd, k[1:0])
      `CHK(lastTxn[16:15], k[1:0])
      `CHK(lastTxn[28], k != 2)
    end
    $display("test codes done");
    setq(32'h00086315, 8'h00, 32'h80);
    settd(32, 32'ha0, tok(1, 16, 0, 3, 1, 8'h80));
    settd(40, 32'h1, tok(1, 8, 0, 3, 1, 8'h80));
    run(0, 1, 0);
    `CHK(nTxn, 3)
    `CHK(P.mem[34], tok(1, 0, 0, 3, 1, 8'h00))
    `CHK(P.mem[42], tok(0, 0, 0, 3, 1, 8'h00))
    `CHK(P.mem[19], 32'ha0)
    $display("test chain done");
    setq(CH | 32'h2000, 8'h00, 32'h80);
    settd(32, 32'h1, tok(1, 8, 0, 3, 0, 8'h81));
    run(0, 0, 0);
    `CHK(firstTok, 8'hb4)
    `CHK(lastTxn[47:40], 8'he1)
    `CHK(P.mem[34], tok(0, 0, 0, 3, 0, 8'h00))
    $display("test ping done");
    for (k = 0; k < 4; k++)
    begin
      setq(CH, 8'h00, 32'h80);
      settd(32, 32'h1, tok(1, 8, 0, (k == 3) ? 2'h1 : 2'h3, 1, 8'h80));
      errEn = (k != 1);
      run(eCode[k], 0, k == 3);
      `CHK(P.mem[34][7:0], eSt[k])
      `CHK(nTxn, eN[k])
      `CHK(nErr, int'(k != 1))
      if (k == 0)
        `CHK(P.mem[22], tok(1, 8, 0, 0, 1, 8'h48))
    end
    $display("test errors done");
    setq(CH, 8'h00, 32'h80);
    settd(32, 32'h1, tok(1, 8, 0, 3, 1, 8'h00));
    run(0, 0, 0);
    `CHK(nTxn, 0)
    settd(32, 32'h1, tok(1, 0, 0, 3, 1, 8'h80));
    run(0, 0, 0);
    `CHK(nTxn, 1)
    `CHK(lastTxn[27:17], 11'h0)
    `CHK(P.mem[34], tok(0, 0, 0, 3, 1, 8'h00))
    setq(CH, 8'h04, 32'h80);
    for (k = 1; k < 3; k++)
    begin
      settd(32, 32'h1, tok(1, 8, 0, 3, 1, 8'h80));
      uframe = k[2:0];
      run(0, 0, 0);
      `CHK(nTxn, k - 1)
    end
    setq(CH, 8'h00, 32'h81);
    run(0, 0, 0);
    `CHK(nTxn, 0)
    $display("test skip done");
    printVerdict;
  end
endmodule // tb_top
